// ==== ssc_peer.sv ====
// Behavioural serial peer: one byte each way per frame.
// Assumes device half periods of six or more bus cycles.
`timescale 1ns/1ps
`default_nettype none
module ssc_peer (
  // Bench control
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       ext,
  input  wire logic       pol,
  input  wire logic       msb,
  input  wire logic [7:0] tx,
  // Serial side
  input  wire logic       dev_clk,
  input  wire logic       sout,
  output logic            sclk,
  output logic            sin,
  output logic      [7:0] rx,
  output logic      [3:0] cnt
);
  logic       lc;
  logic       pc = 1'b1;
  logic [2:0] hp = 3'h0;
  logic [4:0] tk = 5'h10;
  logic [2:0] ix;
  // Own clock rests at the idle level outside frames
  assign sclk = ~pol ^ tk[0];
  assign lc   = ext ? sclk : dev_clk;
  assign ix   = msb ? 3'h7 - cnt[2:0] : cnt[2:0];
  initial begin
    sin = 1'b1;
    cnt = 4'h8;
    rx  = 8'h00;
  end
  always @(posedge clk) begin
    pc <= lc;
    if (go) begin
      cnt <= 4'h0;
      tk  <= 5'h00;
      hp  <= 3'h0;
    end else if (ext && tk < 5'h10) begin
      hp <= hp + 3'h1;
      if (hp == 3'h7) tk <= tk + 5'h01;
    end
    // Drive on the leading edge, sample on the trailing edge
    if (lc != pc && lc == pol && cnt < 4'h8) sin <= tx[ix];
    if (lc != pc && lc != pol && cnt < 4'h8) begin
      rx[ix] <= sout;
      cnt    <= cnt + 4'h1;
      // Released line shows the inverse of its last level
      if (cnt == 4'h7) sin <= ~sin;
    end
  end
endmodule
`default_nettype wire

// ==== ssc_pkg.sv ====
// Constants, field layouts and state types of the synchronous serial channel.
// Assumes an AHB-Lite master with whole-word single transfers.
package ssc_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_DIV   = 8'h04;
  localparam logic [7:0] A_TXBUF = 8'h08;
  localparam logic [7:0] A_RXBUF = 8'h0C;
  localparam logic [7:0] A_STAT  = 8'h10;

  // ---------------------------------------------------------------------
  // Field layouts and codes
  // ---------------------------------------------------------------------
  localparam int ST_TXE   = 0;
  localparam int ST_TXIDL = 1;
  localparam int ST_RXF   = 2;
  localparam int ST_OVR   = 3;
  localparam int ST_TXIRQ = 4;
  localparam int ST_RXIRQ = 5;

  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_CTS  = 2'h1;
  localparam logic [1:0] FLOW_RTS  = 2'h2;

  localparam logic [1:0] PRE_F1  = 2'h0;
  localparam logic [1:0] PRE_F8  = 2'h1;
  localparam logic [1:0] PRE_F32 = 2'h2;
  localparam logic [4:0] PRE_T1  = 5'h00;
  localparam logic [4:0] PRE_T8  = 5'h07;
  localparam logic [4:0] PRE_T32 = 5'h1F;

  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic       LINE_IDLE  = 1'h1;
  localparam logic [7:0] INV_MASK   = 8'hFF;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic {SSC_IDLE, SSC_SHIFT} ssc_phase_t;

  typedef struct packed {
    logic [1:0] pre_sel;
    logic [1:0] flow;
    logic       open_drain;
    logic       line_inv;
    logic       data_inv;
    logic       clk_pin_sel;
    logic       tx_irq_end;
    logic       cont_rx;
    logic       msb_first;
    logic       clk_pol;
    logic       ext_clk;
    logic       rx_en;
    logic       tx_en;
  } ssc_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } ssc_ap_t;

  typedef struct packed {
    ssc_ap_t    ap;
    logic [31:0] rdata;
    ssc_ctrl_t  ctrl;
    logic [7:0] div;
    logic [7:0] tbuf;
    logic       tbuf_full;
    logic [7:0] tsr;
    logic [7:0] rsr;
    logic [7:0] rbuf;
    logic       rx_full;
    logic       overrun;
    logic       tx_irq;
    logic       rx_irq;
    logic       cont_arm;
    ssc_phase_t state;
    logic       rx_act;
    logic [3:0] bits;
    logic       phase;
    logic [4:0] pre_cnt;
    logic [7:0] div_cnt;
    logic [2:0] sin_s;
    logic [2:0] sclk_s;
    logic [2:0] cts_s;
    logic       sin_f;
    logic       sclk_f;
    logic       cts_f;
    logic       out_bit;
    logic       ran;
    logic       sout;
    logic       sclk;
  } ssc_st_t;

endpackage

// ==== ssc_tb.sv ====
// Self-checking bench of the serial channel over AHB-Lite.
// Assumes ssc_top and ssc_peer are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        cts_n = 1'b1, go = 1'b0, pext = 1'b0, ppol = 1'b0;
  logic        pmsb = 1'b0, pdc = 1'b1;
  logic [7:0]  ptx = 8'h00;
  logic [9:0]  hc = 10'h000, half = 10'h000;
  int          err_count = 0, checks = 0;
  wire [31:0]  hrdata;
  wire [7:0]   prx;
  wire [3:0]   pcnt;
  wire         hready, hresp, so_o, so_oe, sc_o, sc_oe, ca_o, ca_oe;
  wire         rts_n, tx_irq_req, rx_irq_req, psclk, psin, dclk, sout;
  assign dclk = sc_oe ? sc_o : ca_oe ? ca_o : 1'b1;
  assign sout = so_oe ? so_o : 1'b1; // Pull-up when open drain
  always #5 hclk = ~hclk;
  ssc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .serial_in_pin(psin), .serial_out_pin_o(so_o),
    .serial_out_pin_oe(so_oe), .serial_clock_pin_i(psclk),
    .serial_clock_pin_o(sc_o), .serial_clock_pin_oe(sc_oe),
    .clock_alt_pin_o(ca_o), .clock_alt_pin_oe(ca_oe), .cts_n(cts_n),
    .rts_n(rts_n), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req));
  ssc_peer u_peer (.clk(hclk), .go(go), .ext(pext), .pol(ppol),
    .msb(pmsb), .tx(ptx), .dev_clk(dclk), .sout(sout), .sclk(psclk),
    .sin(psin), .rx(prx), .cnt(pcnt));
  // ---------------------------------------------------------------------
  // Half period of the transfer clock in bus cycles
  // ---------------------------------------------------------------------
  always @(posedge hclk) begin
    pdc <= dclk;
    if (dclk !== pdc) begin
      half <= hc + 10'h001;
      hc   <= 10'h000;
    end else hc <= hc + 10'h001;
  end
  // ---------------------------------------------------------------------
  // Bus and wait tasks
  // ---------------------------------------------------------------------
  task complete_run;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wt;
    int i;
    i = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && i < 100) begin
      i++;
      @(posedge hclk);
    end
    if (hready !== 1'b1) begin
      err_count++;
      complete_run;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    wt;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    q = hrdata;
  endtask
  task automatic wrw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdw(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic wait_peer;
    int i;
    for (i = 0; i < 6000 && pcnt !== 4'h8; i++) @(posedge hclk);
    if (pcnt !== 4'h8) begin
      err_count++;
      complete_run;
    end
    repeat (12) @(posedge hclk);
  endtask
  task automatic kick;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
  endtask
  // One frame; peer data always checked, receive buffer only when rd is set
  task automatic xfer(input logic [14:0] c, input logic [7:0] dv,
                      input logic [7:0] d, input logic ri, input logic rd);
    logic [7:0]  m;
    logic [31:0] q;
    m = (c[8] ^ c[9]) ? 8'hFF : 8'h00;
    ppol <= c[3];
    pmsb <= c[4];
    pext <= c[2];
    ptx  <= d ^ 8'h96;
    wrw(ssc_pkg::A_CTRL, {17'h0, c});
    wrw(ssc_pkg::A_DIV, {24'h0, dv});
    wrw(ssc_pkg::A_TXBUF, {24'h0, d});
    kick;
    repeat (3) @(posedge hclk);
    `CHK("tx_irq early", ~c[6], tx_irq_req)
    wait_peer;
    `CHK("peer rx", d ^ m, prx)
    `CHK("tx_irq end", 1'b1, tx_irq_req)
    `CHK("rx_irq", ri, rx_irq_req)
    if (rd) begin
      rdw(ssc_pkg::A_RXBUF, q);
      `CHK("rxbuf", {24'h0, ptx ^ m}, q)
    end
  endtask
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    `CHK("out idle", 1'b1, sout)
    `CHK("clk idle", 1'b1, sc_o)
    `CHK("hresp okay", 1'b0, hresp)
    rdw(ssc_pkg::A_STAT, q);
    `CHK("status", 32'h3, q)
    wrw(8'h14, 32'hFFFFFFFF);
    rdw(8'h14, q);
    `CHK("unmapped", 32'h0, q)
  endtask
  task automatic t_modes;
    logic [14:0] cf [0:8];
    logic [7:0]  dv [0:8];
    logic [9:0]  hf [0:8];
    cf = '{15'h0003, 15'h20DB, 15'h4043, 15'h0001, 15'h0007, 15'h000F,
           15'h0113, 15'h0203, 15'h0403};
    dv = '{8'h05, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h05, 8'h05, 8'h05};
    hf = '{10'h006, 10'h008, 10'h020, 10'h100, 10'h000, 10'h000, 10'h006,
           10'h006, 10'h006};
    for (int i = 0; i < 9; i++) begin
      xfer(cf[i], dv[i], 8'hA5 ^ 8'(i), cf[i][1], cf[i][1]);
      if (!cf[i][2]) `CHK("half period", hf[i], half)
      if (i == 1) `CHK("alt clock pin", 2'b10, {ca_oe, sc_oe})
      if (i == 4) `CHK("ext clock pin", 1'b0, sc_oe)
      wrw(ssc_pkg::A_STAT, 32'h38);
    end
  endtask
  task automatic t_overrun;
    logic [31:0] q;
    xfer(15'h0003, 8'h05, 8'h11, 1'b1, 1'b0);
    wrw(ssc_pkg::A_STAT, 32'h30);
    xfer(15'h0003, 8'h05, 8'h22, 1'b0, 1'b1);
    rdw(ssc_pkg::A_STAT, q);
    `CHK("overrun status", 32'h1B, q)
    wrw(ssc_pkg::A_STAT, 32'h38);
  endtask
  task automatic t_cont;
    logic [31:0] q;
    xfer(15'h0023, 8'h05, 8'h81, 1'b1, 1'b1);
    ptx <= 8'h3C;
    kick;
    wait_peer;
    wrw(ssc_pkg::A_CTRL, 32'h3);
    rdw(ssc_pkg::A_RXBUF, q);
    `CHK("cont rxbuf", 32'h3C, q)
    `CHK("dummy out", 8'h81, prx)
    wrw(ssc_pkg::A_STAT, 32'h38);
  endtask
  task automatic t_flow;
    logic [31:0] q;
    ppol <= 1'b0;
    pext <= 1'b0;
    ptx  <= 8'h00;
    wrw(ssc_pkg::A_CTRL, 32'h0803);
    wrw(ssc_pkg::A_TXBUF, 32'h5A);
    repeat (30) @(posedge hclk);
    rdw(ssc_pkg::A_STAT, q);
    `CHK("cts held", 2'b10, q[1:0])
    cts_n <= 1'b0;
    kick;
    wait_peer;
    `CHK("cts frame", 8'h5A, prx)
    rdw(ssc_pkg::A_RXBUF, q);
    wrw(ssc_pkg::A_CTRL, 32'h1003);
    repeat (2) @(posedge hclk);
    `CHK("rts on", 1'b0, rts_n)
    wrw(ssc_pkg::A_CTRL, 32'h0003);
    repeat (2) @(posedge hclk);
    `CHK("rts off", 1'b1, rts_n)
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_modes;
    t_overrun;
    t_cont;
    t_flow;
    complete_run;
  end
endmodule
`default_nettype wire

// ==== ssc_top.sv ====
// Synchronous serial channel: 8-bit frames, internal or external clock,
// register access over AHB-Lite. Pins are sampled through synchronisers.
`timescale 1ns/1ps
`default_nettype none

module ssc_top (
  // Bus clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial pins
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  output logic             clock_alt_pin_o,
  output logic             clock_alt_pin_oe,
  input  wire logic        cts_n,
  output logic             rts_n,
  // Request flags
  output logic             tx_irq_req,
  output logic             rx_irq_req
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [4:0] pre_term(input logic [1:0] sel);
    logic [4:0] t;
    unique case (sel)
      ssc_pkg::PRE_F8:  t = ssc_pkg::PRE_T8;
      ssc_pkg::PRE_F32: t = ssc_pkg::PRE_T32;
      default:          t = ssc_pkg::PRE_T1;
    endcase
    return t;
  endfunction

  function automatic logic [31:0] read_word(input ssc_pkg::ssc_st_t s,
                                            input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    unique case (a)
      ssc_pkg::A_CTRL:  w[$bits(ssc_pkg::ssc_ctrl_t)-1:0] = s.ctrl;
      ssc_pkg::A_DIV:   w[7:0] = s.div;
      ssc_pkg::A_TXBUF: w[7:0] = s.tbuf;
      ssc_pkg::A_RXBUF: w[7:0] = s.rbuf ^ (s.ctrl.data_inv ?
                                 ssc_pkg::INV_MASK : '0);
      ssc_pkg::A_STAT: begin
        w[ssc_pkg::ST_TXE]   = ~s.tbuf_full;
        w[ssc_pkg::ST_TXIDL] = (s.state == ssc_pkg::SSC_IDLE);
        w[ssc_pkg::ST_RXF]   = s.rx_full;
        w[ssc_pkg::ST_OVR]   = s.overrun;
        w[ssc_pkg::ST_TXIRQ] = s.tx_irq;
        w[ssc_pkg::ST_RXIRQ] = s.rx_irq;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  ssc_pkg::ssc_st_t cur;
  ssc_pkg::ssc_st_t nx;
  logic             load_ev;
  logic             end_ev;
  logic             rx_ev;
  logic             go;
  logic             idle_lvl;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic       ap_now;
    logic       cts_ok;
    logic       ext_ok;
    logic       tick;
    logic       half;
    logic       lead;
    logic       trail;
    logic       in_bit;
    logic [7:0] rsr_n;
    ap_now   = hsel && htrans[1] && hready;
    cts_ok   = 1'b0;
    ext_ok   = 1'b0;
    tick     = 1'b0;
    half     = 1'b0;
    lead     = 1'b0;
    trail    = 1'b0;
    in_bit   = 1'b0;
    rsr_n    = '0;
    nx       = cur;
    load_ev  = 1'b0;
    end_ev   = 1'b0;
    rx_ev    = 1'b0;
    idle_lvl = ~cur.ctrl.clk_pol;
    // Synchronisers: change counts once second and third stage agree
    nx.sin_s  = {cur.sin_s[1:0], serial_in_pin};
    nx.sclk_s = {cur.sclk_s[1:0], serial_clock_pin_i};
    nx.cts_s  = {cur.cts_s[1:0], cts_n};
    if (cur.sin_s[1] == cur.sin_s[2]) nx.sin_f = cur.sin_s[2];
    if (cur.sclk_s[1] == cur.sclk_s[2]) nx.sclk_f = cur.sclk_s[2];
    if (cur.cts_s[1] == cur.cts_s[2]) nx.cts_f = cur.cts_s[2];

    // Bus address phase; reads are answered from the address phase
    nx.ap.valid = ap_now;
    nx.ap.write = hwrite;
    nx.ap.addr  = haddr[7:0];
    if (ap_now && !hwrite) begin
      nx.rdata = read_word(cur, haddr[7:0]);
      if (haddr[7:0] == ssc_pkg::A_RXBUF) begin
        nx.rx_full = 1'b0;
        if (cur.ctrl.cont_rx && cur.ctrl.rx_en) nx.cont_arm = 1'b1;
      end
    end
    // Bus data phase writes; overrun and request status bits clear on writing one
    if (cur.ap.valid && cur.ap.write) begin
      unique case (cur.ap.addr)
        ssc_pkg::A_CTRL: nx.ctrl = hwdata[$bits(ssc_pkg::ssc_ctrl_t)-1:0];
        ssc_pkg::A_DIV:  nx.div  = hwdata[7:0];
        ssc_pkg::A_STAT: begin
          if (hwdata[ssc_pkg::ST_OVR])   nx.overrun = 1'b0;
          if (hwdata[ssc_pkg::ST_TXIRQ]) nx.tx_irq  = 1'b0;
          if (hwdata[ssc_pkg::ST_RXIRQ]) nx.rx_irq  = 1'b0;
        end
        default: ;
      endcase
    end

    // Frame start
    cts_ok = (cur.ctrl.flow != ssc_pkg::FLOW_CTS) || !cur.cts_f;
    ext_ok = !cur.ctrl.ext_clk || (cur.sclk_f == idle_lvl);
    go = (cur.state == ssc_pkg::SSC_IDLE) && cur.ctrl.tx_en && cts_ok &&
         ext_ok && (cur.tbuf_full || cur.cont_arm);
    if (go) begin
      nx.state    = ssc_pkg::SSC_SHIFT;
      nx.rx_act   = cur.ctrl.rx_en;
      nx.cont_arm = 1'b0;
      nx.bits     = '0;
      nx.phase    = 1'b0;
      nx.pre_cnt  = '0;
      nx.div_cnt  = '0;
      // Continuous receive resends the last written word as dummy data
      nx.tsr = cur.tbuf;
      if (cur.tbuf_full) begin
        nx.tbuf_full = 1'b0;
        load_ev      = 1'b1;
        if (!cur.ctrl.tx_irq_end) nx.tx_irq = 1'b1;
      end
    end

    // Internal clock: prescaler then divider, div plus one ticks per half period
    tick = (cur.pre_cnt == pre_term(cur.ctrl.pre_sel));
    half = 1'b0;
    if (cur.state == ssc_pkg::SSC_SHIFT && !cur.ctrl.ext_clk) begin
      nx.pre_cnt = tick ? '0 : cur.pre_cnt + 5'h01;
      if (tick) begin
        nx.div_cnt = (cur.div_cnt == cur.div) ? '0 : cur.div_cnt + 8'h01;
        half = (cur.div_cnt == cur.div);
      end
      if (half) nx.phase = ~cur.phase;
    end
    // Leading edge drives, trailing edge samples; both share one clock
    if (cur.ctrl.ext_clk) begin
      lead  = (nx.sclk_f != cur.sclk_f) && (nx.sclk_f != idle_lvl);
      trail = (nx.sclk_f != cur.sclk_f) && (nx.sclk_f == idle_lvl);
    end else begin
      lead  = half && !cur.phase;
      trail = half && cur.phase;
    end
    lead  = lead && (cur.state == ssc_pkg::SSC_SHIFT);
    trail = trail && (cur.state == ssc_pkg::SSC_SHIFT);
    if (lead) begin
      nx.out_bit = cur.ctrl.msb_first ? cur.tsr[7] : cur.tsr[0];
      nx.ran     = 1'b1;
    end
    in_bit = cur.sin_f ^ cur.ctrl.line_inv;
    rsr_n  = cur.ctrl.msb_first ? {cur.rsr[6:0], in_bit} :
                                  {in_bit, cur.rsr[7:1]};
    if (trail) begin
      nx.tsr  = cur.ctrl.msb_first ? {cur.tsr[6:0], 1'b0} :
                                     {1'b0, cur.tsr[7:1]};
      nx.rsr  = rsr_n;
      nx.bits = cur.bits + 4'h1;
      if (cur.bits == ssc_pkg::FRAME_BITS - 4'h1) begin
        end_ev   = 1'b1;
        nx.state = ssc_pkg::SSC_IDLE;
        if (cur.ctrl.tx_irq_end) nx.tx_irq = 1'b1;
        if (cur.rx_act) begin
          rx_ev   = 1'b1;
          nx.rbuf = rsr_n;
          if (nx.rx_full) begin
            nx.overrun = 1'b1;
          end else begin
            nx.rx_full = 1'b1;
            nx.rx_irq  = 1'b1;
          end
        end
      end
    end

    // Transmit buffer write wins over a load in the same cycle
    if (cur.ap.valid && cur.ap.write && cur.ap.addr == ssc_pkg::A_TXBUF)
    begin
      nx.tbuf = hwdata[7:0] ^ (cur.ctrl.data_inv ?
                               ssc_pkg::INV_MASK : '0);
      nx.tbuf_full = 1'b1;
    end

    // Registered pin levels
    nx.sout = nx.ran ? (nx.out_bit ^ nx.ctrl.line_inv) :
                       ssc_pkg::LINE_IDLE;
    nx.sclk = (nx.state == ssc_pkg::SSC_SHIFT && nx.phase) ?
              nx.ctrl.clk_pol : ~nx.ctrl.clk_pol;
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur         <= '0;
      cur.out_bit <= ssc_pkg::LINE_IDLE;
      cur.sout    <= ssc_pkg::LINE_IDLE;
      cur.sclk    <= ssc_pkg::LINE_IDLE;
    end else begin
      cur <= nx;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign hrdata              = cur.rdata;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign serial_out_pin_o    = cur.ctrl.open_drain ? 1'b0 : cur.sout;
  assign serial_out_pin_oe   = cur.ctrl.open_drain ? ~cur.sout : 1'b1;
  assign serial_clock_pin_o  = cur.sclk;
  assign serial_clock_pin_oe = !cur.ctrl.ext_clk && !cur.ctrl.clk_pin_sel;
  assign clock_alt_pin_o     = cur.sclk;
  assign clock_alt_pin_oe    = !cur.ctrl.ext_clk && cur.ctrl.clk_pin_sel;
  assign rts_n               = (cur.ctrl.flow == ssc_pkg::FLOW_RTS) ?
                               !(cur.ctrl.rx_en && !cur.rx_full) :
                               1'b1;
  assign tx_irq_req          = cur.tx_irq;
  assign rx_irq_req          = cur.rx_irq;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  function automatic logic ap_rd_rx();
    return hsel && htrans[1] && hready && !hwrite &&
           haddr[7:0] == ssc_pkg::A_RXBUF;
  endfunction

  a_idle_out_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !cur.ran && !cur.ctrl.open_drain |-> serial_out_pin_o)
    else $error("serial output not high before first frame");
  a_start_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(cur.state) == ssc_pkg::SSC_IDLE &&
    cur.state == ssc_pkg::SSC_SHIFT |-> $past(cur.ctrl.tx_en))
    else $error("frame started without transmit enable");
  a_cts_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(cur.state) == ssc_pkg::SSC_IDLE &&
    cur.state == ssc_pkg::SSC_SHIFT &&
    $past(cur.ctrl.flow) == ssc_pkg::FLOW_CTS |-> !$past(cur.cts_f))
    else $error("frame started while clear-to-send high");
  a_ext_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(cur.state) == ssc_pkg::SSC_IDLE &&
    cur.state == ssc_pkg::SSC_SHIFT && $past(cur.ctrl.ext_clk)
    |-> $past(cur.sclk_f) != $past(cur.ctrl.clk_pol))
    else $error("external frame started off idle clock level");
  a_load_irq: assert property (
    @(posedge hclk) disable iff (!hresetn)
    load_ev && !cur.ctrl.tx_irq_end |=> tx_irq_req)
    else $error("no transmit request on buffer load");
  a_end_irq: assert property (
    @(posedge hclk) disable iff (!hresetn)
    end_ev && cur.ctrl.tx_irq_end |=> tx_irq_req)
    else $error("no transmit request at frame end");
  a_rx_irq_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_ev && !cur.rx_full |=> rx_irq_req && cur.rx_full)
    else $error("no receive request on buffer fill");
  a_overrun_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_ev && cur.rx_full && !(ap_rd_rx()) |=> cur.overrun)
    else $error("overrun not flagged");
  a_rxirq_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_ev && cur.rx_full && !(ap_rd_rx()) && !(cur.ap.valid &&
    cur.ap.write && cur.ap.addr == ssc_pkg::A_STAT)
    |=> $stable(rx_irq_req))
    else $error("receive request changed on overrun");
  a_clk_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cur.state == ssc_pkg::SSC_IDLE && $past(cur.state) ==
    ssc_pkg::SSC_IDLE && $stable(cur.ctrl.clk_pol)
    |-> serial_clock_pin_o == ~cur.ctrl.clk_pol)
    else $error("transfer clock not idle outside frame");
  a_clk_one_pin: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !cur.ctrl.ext_clk |-> serial_clock_pin_oe != clock_alt_pin_oe)
    else $error("internal clock not on exactly one pin");
  a_rts_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cur.ctrl.flow == ssc_pkg::FLOW_RTS && cur.ctrl.rx_en &&
    !cur.rx_full |-> !rts_n)
    else $error("request-to-send not asserted while ready");
  a_frame_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    end_ev |-> cur.bits == ssc_pkg::FRAME_BITS - 4'h1 ##1
    cur.state == ssc_pkg::SSC_IDLE)
    else $error("frame did not end after eight bits");

endmodule

`default_nettype wire
